/* File: hw/vvc_pkg.sv */
// Shared constants and types of the voice VLAN classifier.
// Assumes one switch core clock; all users import the whole package.
package vvc_pkg;
  localparam int NUM_PORTS = 8;       // Ports handled by the classifier
  localparam int PORT_W = 3;          // Width of a port number
  localparam int OUI_ENTRIES = 8;     // Prefix table depth
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_VID = 12'h004;
  localparam logic [11:0] OFS_AGING = 12'h008;
  localparam logic [11:0] OFS_PORT_EN = 12'h00c;
  localparam logic [11:0] OFS_MEMBER = 12'h010;
  localparam logic [11:0] OFS_OUI_BASE = 12'h040;
  // Control register fields and prefix entry valid bit
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RW_BIT = 1;
  localparam int CTRL_PRI_LSB = 2;
  localparam int OUI_VALID_BIT = 24;
  // Reset values and limits
  localparam logic [2:0] PRI_RESET = 3'h6;
  localparam logic [11:0] VID_RESET = 12'h001;
  localparam logic [11:0] VID_MIN = 12'h001;
  localparam logic [16:0] AGING_RESET = 17'h005a0;  // 1440 minutes
  localparam logic [16:0] AGING_MIN = 17'h0001e;    // 30 minutes
  localparam logic [16:0] AGING_MAX = 17'h10000;    // 65536 minutes
  // Minute tick timing
  localparam longint CLK_HZ = 10_000_000;
  localparam longint MINUTE_S = 60;
  localparam longint MINUTE_CYCLES = CLK_HZ * MINUTE_S;
  // Frame descriptor carried through the buffer
  typedef struct packed {
    logic [PORT_W-1:0] port;
    logic [11:0] vid;
    logic [2:0] pri;
    logic voice;
  } vvc_desc_s;
  localparam int DESC_W = $bits(vvc_desc_s);
endpackage : vvc_pkg

/* File: hw/vvc_strm_if.sv */
// Valid/ready stream carrier between the classifier and its buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface vvc_strm_if #(parameter int W = 8);
  logic valid; // Word offered
  logic ready; // Word accepted when valid too
  logic [W-1:0] data; // Payload
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : vvc_strm_if
`default_nettype wire

/* File: hw/vvc_skid.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes a synchronous active-high reset and a shared clock enable.
`timescale 1ns/1ps
`default_nettype none
module vvc_skid #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  vvc_strm_if.snk up,
  vvc_strm_if.src dn
);
  logic [W-1:0] mem_q [2]; // Storage for two words
  logic wp_q; // Write slot
  logic rp_q; // Read slot
  logic [1:0] cnt_q; // Words held
  logic push;
  logic pop;

  // Handshakes on each side
  assign push = up.valid && (cnt_q != 2'h2);
  assign pop = dn.valid && dn.ready;
  // Full and empty are honest: ready is taken from the count flop
  assign up.ready = (cnt_q != 2'h2);
  assign dn.valid = (cnt_q != 2'h0);
  assign dn.data = mem_q[rp_q];

  // Store incoming words
  always_ff @(posedge clk)
  begin
    if (ce && push)
    begin
      mem_q[wp_q] <= up.data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else if (ce)
    begin
      if (push)
      begin
        wp_q <= ~wp_q;
      end
      if (pop)
      begin
        rp_q <= ~rp_q;
      end
      // Simultaneous push and pop leave the count alone
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // vvc_skid
`default_nettype wire

/* File: hw/vvc_top.sv */
// Voice VLAN classifier: APB registers, prefix match, membership aging.
// Assumes frame descriptors arrive on the core clock, one per handshake.
// Behaviour
// - Source MAC prefix match selects voice VLAN.
// - Global enable, off at reset, gates classification.
// - Voice VID 1..4095, reads none while off.
// - Voice priority register resets to six.
// - Rewrite enable off; otherwise priority kept.
// - Port leaves membership after aging time idle.
// - Membership follows MAC, not the port.
// - Per-port enable, off at reset, gates participation.
`timescale 1ns/1ps
`default_nettype none
module vvc_top
  import vvc_pkg::*;
#(
  parameter longint TICK_CYCLES = MINUTE_CYCLES // Cycles per aging minute
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [PORT_W-1:0] IN_PORT,
  input wire logic [47:0] IN_SRC_MAC,
  input wire logic [11:0] IN_VID,
  input wire logic [2:0] IN_PRI,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [PORT_W-1:0] OUT_PORT,
  output logic [11:0] OUT_VID,
  output logic [2:0] OUT_PRI,
  output logic OUT_VOICE,
  output logic [NUM_PORTS-1:0] MEMBER
);
  // Configuration state
  logic glb_en_q; // Voice operation on
  logic rw_en_q; // Priority rewrite on
  logic [2:0] vpri_q; // Priority given to voice frames
  logic [11:0] vvid_q; // Voice VLAN identifier
  logic [16:0] aging_q; // Aging time in minutes
  logic [NUM_PORTS-1:0] port_en_q; // Per-port enables
  logic [24:0] oui_q [OUI_ENTRIES]; // Valid bit and prefix
  // Membership state
  logic [NUM_PORTS-1:0] member_q;
  logic [16:0] age_q [NUM_PORTS];
  logic [29:0] tick_cnt_q;
  logic tick;
  // Bus signals
  logic acc; // Access phase completing this edge
  logic wr;
  logic [31:0] rdata_d;
  logic unmapped;
  logic oui_hit;
  logic [2:0] oui_idx;
  // Classification
  logic match;
  logic voice;
  logic take;
  vvc_desc_s desc;

  vvc_strm_if #(.W(DESC_W)) up_if ();
  vvc_strm_if #(.W(DESC_W)) dn_if ();

  // Completion happens on the edge where the registered ready is seen
  assign acc = PSEL && PENABLE && PREADY;
  assign wr = acc && PWRITE;
  assign oui_hit = (PADDR[11:5] == OFS_OUI_BASE[11:5]) && (PADDR[1:0] == 2'h0);
  assign oui_idx = PADDR[4:2];

  // Read decode; unmapped addresses read zero and flag an error
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    unmapped = 1'b0;
    if (oui_hit)
    begin
      rdata_d = {7'h00, oui_q[oui_idx]};
    end
    else
    begin
      case (PADDR)
        OFS_CTRL: rdata_d = {27'h0, vpri_q, rw_en_q, glb_en_q};
        // Identifier reads as none (zero) while voice operation is off
        OFS_VID: rdata_d = glb_en_q ? {20'h0, vvid_q} : 32'h0000_0000;
        OFS_AGING: rdata_d = {15'h0, aging_q};
        OFS_PORT_EN: rdata_d = {{(32-NUM_PORTS){1'b0}}, port_en_q};
        OFS_MEMBER: rdata_d = {{(32-NUM_PORTS){1'b0}}, member_q};
        default: unmapped = 1'b1;
      endcase
    end
  end

  // One wait state: ready rises the cycle after the access phase begins
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else if (CLK_EN)
    begin
      PREADY <= PSEL && PENABLE && !PREADY;
      if (PSEL && PENABLE && !PREADY)
      begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rdata_d;
        PSLVERR <= unmapped;
      end
    end
  end

  // Global controls and priority
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      glb_en_q <= 1'b0;
      rw_en_q <= 1'b0;
      vpri_q <= PRI_RESET;
    end
    else if (CLK_EN && wr && (PADDR == OFS_CTRL))
    begin
      glb_en_q <= PWDATA[CTRL_EN_BIT];
      rw_en_q <= PWDATA[CTRL_RW_BIT];
      vpri_q <= PWDATA[CTRL_PRI_LSB +: 3];
    end
  end

  // Identifier and aging time; writes outside the legal range are dropped
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      vvid_q <= VID_RESET;
      aging_q <= AGING_RESET;
    end
    else if (CLK_EN && wr)
    begin
      if ((PADDR == OFS_VID) && (PWDATA[11:0] >= VID_MIN))
      begin
        vvid_q <= PWDATA[11:0];
      end
      if ((PADDR == OFS_AGING) && (PWDATA[31:0] >= {15'h0, AGING_MIN})
          && (PWDATA[31:0] <= {15'h0, AGING_MAX}))
      begin
        aging_q <= PWDATA[16:0];
      end
    end
  end

  // Port enables
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      port_en_q <= '0;
    end
    else if (CLK_EN && wr && (PADDR == OFS_PORT_EN))
    begin
      port_en_q <= PWDATA[NUM_PORTS-1:0];
    end
  end

  // Prefix table; entries start empty so nothing matches after reset
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < OUI_ENTRIES; i++)
      begin
        oui_q[i] <= 25'h0;
      end
    end
    else if (CLK_EN && wr && oui_hit)
    begin
      oui_q[oui_idx] <= PWDATA[24:0];
    end
  end

  // Compare the vendor prefix against every valid table entry
  always_comb
  begin
    match = 1'b0;
    for (int i = 0; i < OUI_ENTRIES; i++)
    begin
      if (oui_q[i][OUI_VALID_BIT] && (oui_q[i][23:0] == IN_SRC_MAC[47:24]))
      begin
        match = 1'b1;
      end
    end
  end

  // Decision uses the MAC plus the global and port enables, so a moved phone is caught on any enabled port
  assign voice = glb_en_q && port_en_q[IN_PORT] && match;

  // Build the outgoing descriptor
  always_comb
  begin
    desc.port = IN_PORT;
    desc.voice = voice;
    desc.vid = voice ? vvid_q : IN_VID;
    // Without rewrite the original priority passes untouched
    desc.pri = (voice && rw_en_q) ? vpri_q : IN_PRI;
  end

  // Clock enable low blocks the push, but IN_READY is not gated, so a word offered then is lost
  assign up_if.valid = IN_VALID && CLK_EN;
  assign up_if.data = desc;
  assign take = IN_VALID && up_if.ready && CLK_EN;
  assign IN_READY = up_if.ready;

  vvc_skid #(.W(DESC_W)) u_buf (
    .clk(CLOCK),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .up(up_if),
    .dn(dn_if)
  );

  assign OUT_VALID = dn_if.valid;
  assign dn_if.ready = OUT_READY && CLK_EN;
  assign {OUT_PORT, OUT_VID, OUT_PRI, OUT_VOICE} = dn_if.data;

  // Minute tick; the long count is a parameter so simulation can shorten it
  assign tick = (tick_cnt_q == 30'(TICK_CYCLES - 1));
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      tick_cnt_q <= 30'h0;
    end
    else if (CLK_EN)
    begin
      tick_cnt_q <= tick ? 30'h0 : tick_cnt_q + 30'h1;
    end
  end

  // Membership and per-port aging; a voice frame beats expiry in one cycle
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      member_q <= '0;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        age_q[p] <= 17'h0;
      end
    end
    else if (CLK_EN)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        if (!port_en_q[p] || !glb_en_q)
        begin
          // Disabled ports hold no membership
          member_q[p] <= 1'b0;
          age_q[p] <= 17'h0;
        end
        else if (take && voice && (IN_PORT == PORT_W'(p)))
        begin
          member_q[p] <= 1'b1;
          age_q[p] <= 17'h0;
        end
        else if (tick && member_q[p])
        begin
          if (age_q[p] + 17'h1 >= aging_q)
          begin
            member_q[p] <= 1'b0;
            age_q[p] <= 17'h0;
          end
          else
          begin
            age_q[p] <= age_q[p] + 17'h1;
          end
        end
      end
    end
  end

  assign MEMBER = member_q;
endmodule // vvc_top
`default_nettype wire

/* File: bench/vvc_top_sva.sv */
// Checker for the classifier top: APB timing, buffer hold, membership gates.
// Assumes it is bound to vvc_top and sees every APB write it completes.
`timescale 1ns/1ps
`default_nettype none
module vvc_top_sva
  import vvc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IN_VALID,
  input wire logic IN_READY,
  input wire logic [PORT_W-1:0] IN_PORT,
  input wire logic OUT_VALID,
  input wire logic OUT_READY,
  input wire logic [11:0] OUT_VID,
  input wire logic OUT_VOICE,
  input wire logic [NUM_PORTS-1:0] MEMBER
);
  logic en_q; // Mirror of the global enable
  logic [NUM_PORTS-1:0] pe_q; // Mirror of the port enables
  wire logic wr_done = CLK_EN && PSEL && PENABLE && PWRITE && PREADY; // Write lands here
  // Mirrors follow completed writes only, as the registers do
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      en_q <= 1'b0;
      pe_q <= '0;
    end
    else if (wr_done && PADDR == OFS_CTRL) en_q <= PWDATA[CTRL_EN_BIT];
    else if (wr_done && PADDR == OFS_PORT_EN) pe_q <= PWDATA[NUM_PORTS-1:0];
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // Access phase still waiting, and a receiver stall
  sequence s_access; PSEL && PENABLE && !PREADY && CLK_EN; endsequence
  sequence s_stall; OUT_VALID && !OUT_READY && CLK_EN; endsequence
  a_apb_answer: assert property (s_access |=> PREADY)
    else $error("APB access not answered after one wait");
  a_ready_pulse: assert property (PREADY && CLK_EN |=> !PREADY)
    else $error("PREADY longer than one cycle");
  a_err_data: assert property (PREADY && PSLVERR |-> PRDATA == '0)
    else $error("Refused access returned data");
  a_out_hold: assert property (s_stall |=> OUT_VALID && $stable(OUT_VID) && $stable(OUT_VOICE))
    else $error("Output word changed under stall");
  a_voice_vid: assert property (OUT_VALID && OUT_VOICE |-> OUT_VID != 12'h000)
    else $error("Voice word carries VID zero");
  a_global_gate: assert property (!en_q && CLK_EN |=> MEMBER == '0)
    else $error("Membership while globally off");
  a_port_gate: assert property (CLK_EN |=> (MEMBER & ~$past(pe_q)) == '0)
    else $error("Membership on a disabled port");
  a_member_cause: assert property ((MEMBER & ~$past(MEMBER)) != '0 |->
    $past(IN_VALID && IN_READY && CLK_EN) &&
    (MEMBER & ~$past(MEMBER)) == (NUM_PORTS'(1) << $past(IN_PORT)))
    else $error("Membership set without a frame on that port");
endmodule // vvc_top_sva
bind vvc_top vvc_top_sva u_sva (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IN_VALID(IN_VALID),
  .IN_READY(IN_READY), .IN_PORT(IN_PORT), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
  .OUT_VID(OUT_VID), .OUT_VOICE(OUT_VOICE), .MEMBER(MEMBER));
`default_nettype wire

/* File: bench/vvc_phone.sv */
// Voice equipment model: offers frame descriptors on the ingress stream.
// Assumes the classifier samples on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module vvc_phone
  import vvc_pkg::*;
(
  input wire logic clk,
  input wire logic ready,
  output logic valid,
  output logic [PORT_W-1:0] port,
  output logic [47:0] mac,
  output logic [11:0] vid,
  output logic [2:0] pri
);
  // Quiet until the first frame
  initial
  begin
    valid = 1'b0;
    {port, mac, vid, pri} = '0;
  end
  // Hold a frame until taken; then invert the lines so stale data never looks valid
  task automatic send(input logic [2:0] p, input logic [47:0] m, input logic [11:0] v,
                      input logic [2:0] r);
    @(posedge clk);
    valid <= 1'b1;
    {port, mac, vid, pri} <= {p, m, v, r};
    do @(posedge clk); while (ready !== 1'b1);
    valid <= 1'b0;
    {port, mac, vid, pri} <= ~{p, m, v, r};
  endtask
endmodule // vvc_phone
`default_nettype wire

/* File: bench/tb_voice_vlan_classifier.sv */
// Bench: registers over APB, classification, buffer stall and aging.
// Assumes the package is compiled first; one aging minute is 4 cycles here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %0h want %0h", $time, a, b); end end
module tb_voice_vlan_classifier
  import vvc_pkg::*;
;
  localparam logic [47:0] VMAC = 48'h5ac301_000123; // Arbitrary voice prefix
  localparam logic [47:0] DMAC = 48'h5ac302_000123; // Prefix only in a table entry without its valid bit
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic out_ready = 1'b0;
  logic clk_en = 1'b1; // Dropped once to show that a stalled core drains no buffered word
  logic [31:0] prdata, rd;
  logic pready, pslverr, in_ready, in_valid, out_valid, out_voice;
  logic [2:0] in_port, out_port, in_pri, out_pri;
  logic [11:0] in_vid, out_vid;
  logic [47:0] in_mac;
  logic [NUM_PORTS-1:0] member;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  // Clock enable is driven so the freeze path is exercised as well
  vvc_top #(.TICK_CYCLES(4)) dut (.CLOCK(clk), .SYS_RST(rst), .CLK_EN(clk_en), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IN_VALID(in_valid), .IN_READY(in_ready),
    .IN_PORT(in_port), .IN_SRC_MAC(in_mac), .IN_VID(in_vid), .IN_PRI(in_pri),
    .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_PORT(out_port), .OUT_VID(out_vid),
    .OUT_PRI(out_pri), .OUT_VOICE(out_voice), .MEMBER(member));
  vvc_phone ph (.clk(clk), .ready(in_ready), .valid(in_valid), .port(in_port),
    .mac(in_mac), .vid(in_vid), .pri(in_pri));
  // One APB transfer, held until PREADY is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare data and error response
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic er);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(pslverr, er)
  endtask
  // Take one classified word and compare all its fields
  task automatic get(input logic [2:0] p, input logic [11:0] v, input logic [2:0] r,
                     input logic vc);
    @(posedge clk);
    out_ready <= 1'b1;
    do @(posedge clk); while (out_valid !== 1'b1);
    out_ready <= 1'b0;
    `CHK({out_port, out_vid, out_pri, out_voice}, {p, v, r, vc})
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_CTRL, 32'h18, 1'b0);
    rdc(OFS_VID, 32'h0, 1'b0);
    rdc(OFS_AGING, 32'h5a0, 1'b0);
    rdc(OFS_PORT_EN, 32'h0, 1'b0);
    rdc(12'h020, 32'h0, 1'b1);
    // VID 0x064 clashes with no other VLAN here; zero must be ignored
    apb(1'b1, OFS_VID, 32'h64);
    apb(1'b1, OFS_VID, 32'h0);
    apb(1'b1, OFS_AGING, 32'h1d);
    rdc(OFS_AGING, 32'h5a0, 1'b0);
    apb(1'b1, OFS_AGING, 32'h10001);
    apb(1'b1, OFS_AGING, 32'h10000);
    rdc(OFS_AGING, 32'h10000, 1'b0);
    apb(1'b1, OFS_AGING, 32'h1e);
    apb(1'b1, OFS_OUI_BASE + 12'h004, {8'h01, VMAC[47:24]});
    apb(1'b1, OFS_PORT_EN, 32'h05);
    ph.send(3'h0, VMAC, 12'h007, 3'h2);
    get(3'h0, 12'h007, 3'h2, 1'b0);
    // No spanning tree runs beside this block before enabling
    apb(1'b1, OFS_CTRL, 32'h19);
    rdc(OFS_VID, 32'h64, 1'b0);
    // An entry without its valid bit must never match
    apb(1'b1, OFS_OUI_BASE + 12'h008, {8'h00, DMAC[47:24]});
    ph.send(3'h0, VMAC, 12'h007, 3'h2);
    get(3'h0, 12'h064, 3'h2, 1'b1);
    ph.send(3'h0, DMAC, 12'h007, 3'h2);
    get(3'h0, 12'h007, 3'h2, 1'b0);
    ph.send(3'h1, VMAC, 12'h007, 3'h2);
    get(3'h1, 12'h007, 3'h2, 1'b0);
    rdc(OFS_MEMBER, 32'h01, 1'b0);
    // Rewrite on, priority 3; receiver stalls while two words fill the buffer
    apb(1'b1, OFS_CTRL, 32'h0f);
    ph.send(3'h2, VMAC, 12'h009, 3'h0);
    ph.send(3'h2, DMAC, 12'h009, 3'h0);
    @(posedge clk);
    `CHK(in_ready, 1'b0)
    get(3'h2, 12'h064, 3'h3, 1'b1);
    get(3'h2, 12'h009, 3'h0, 1'b0);
    rdc(OFS_MEMBER, 32'h05, 1'b0);
    // Aging of 30 minutes: a second frame restarts the count
    out_ready <= 1'b1;
    ph.send(3'h0, VMAC, 12'h007, 3'h2);
    repeat (60) @(posedge clk);
    ph.send(3'h0, VMAC, 12'h007, 3'h2);
    repeat (110) @(posedge clk);
    `CHK(member[0], 1'b1)
    repeat (15) @(posedge clk);
    `CHK(member[0], 1'b0)
    out_ready <= 1'b0;
    ph.send(3'h0, VMAC, 12'h007, 3'h2);
    // Clock enable low: a willing receiver drains nothing until it returns
    clk_en <= 1'b0;
    out_ready <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(out_valid, 1'b1)
    clk_en <= 1'b1;
    out_ready <= 1'b0;
    get(3'h0, 12'h064, 3'h3, 1'b1);
    rdc(OFS_MEMBER, 32'h01, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0e);
    rdc(OFS_MEMBER, 32'h0, 1'b0);
    rdc(OFS_VID, 32'h0, 1'b0);
    // Reset in mid-run brings the settings back to their reset values
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_CTRL, 32'h18, 1'b0);
    rdc(OFS_PORT_EN, 32'h0, 1'b0);
    end_of_test();
  end
endmodule // tb_voice_vlan_classifier
`default_nettype wire
